// >>> rtl/ppsc_top.sv
/*
  power-management control/status register bank for one function:
  power state field, wake status and enable, data select and scale,
  bridge extension byte, wake output and an event interrupt.
  assumes a single 250 mhz clock, synchronous inputs and a strobe master
  that never needs to wait.
*/
// Overview of operation
// - wake status sets on every wake event
// - writing one clears wake status
// - wake bits zero, or sticky if supported
// - wake output only while enable set
// - data scale read-only, zero when absent
// - data select reads zero when absent
// - power state encodes d0 to d3hot
// - unsupported state write is discarded
// - two-byte register resets to d0
// - read-only bridge extension byte, reset zero
// - bus control off ignores state field
`timescale 1ns/100ps
module ppsc_top #(
  parameter bit         WAKE_FROM_D3COLD = 1'b1,  // sticky wake bits
  parameter bit         D1_SUPPORTED     = 1'b1,  // d1 accepted
  parameter bit         D2_SUPPORTED     = 1'b1,  // d2 accepted
  parameter bit         DATA_IMPL        = 1'b0,  // data register present
  parameter logic [7:0] BRIDGE_VALUE     = 8'h00  // fixed bridge byte
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                func_rst_n,
  // register port
  input  wire ppsc_pkg::ppsc_req_s req,
  output logic              [31:0] rdata,
  // function side
  input  wire logic                wake_event,
  output logic               [1:0] power_state,
  output ppsc_pkg::ppsc_bus_s      sec_bus,
  output logic                     wake_out_n,
  output logic                     irq
);
  import ppsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int IRQ_W_T = PPSC_IRQ_W;  // one status bit per event source
  logic [1:0]          pstate;         // current power state
  logic [3:0]          data_select;    // data select field
  logic                wake_status;    // wake event status
  logic                wake_enable;    // wake event enable
  logic [IRQ_W_T-1:0]  irq_status;     // sticky events
  logic [IRQ_W_T-1:0]  irq_mask;       // event enables
  logic [31:0]         rdata_c;        // combinational read word
  logic [15:0]         ctrl_img;       // control/status image
  logic [7:0]          bridge_img;     // bridge extension image

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // is the access aimed at the given offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  // is a requested state one the function accepts
  function automatic logic state_ok(input logic [1:0] s);
    case (s)
      PPSC_D1: state_ok = D1_SUPPORTED;
      PPSC_D2: state_ok = D2_SUPPORTED;
      default: state_ok = 1'b1;
    endcase
  endfunction : state_ok

  logic wr_cs;   // write to control/status
  logic rd_irq;  // read of interrupt status
  logic [1:0] wr_state;
  logic state_accept;

  assign wr_cs        = req.wr && hit(req.addr, PPSC_OFF_PWR_CTRL_STAT);
  assign rd_irq       = req.rd && hit(req.addr, PPSC_OFF_IRQ_STATUS);
  assign wr_state     = req.wdata[PPSC_POS_STATE_LO +: 2];
  assign state_accept = wr_cs && state_ok(wr_state);

  // ----------------------------------------------------------------
  // wake flags
  // ----------------------------------------------------------------
  // status sets on every event whatever the enable; write one clears
  ppsc_sticky_bit #(
    .STICKY (WAKE_FROM_D3COLD)
  ) u_wake_status (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .func_rst_n (func_rst_n),
    .set        (wake_event),
    .clr        (wr_cs && req.wdata[PPSC_POS_WAKE_STATUS]),
    .wr_en      (1'b0),
    .wr_val     (1'b0),
    .q          (wake_status)
  );

  // enable is a plain read/write bit, sticky on the same terms
  ppsc_sticky_bit #(
    .STICKY (WAKE_FROM_D3COLD)
  ) u_wake_enable (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .func_rst_n (func_rst_n),
    .set        (1'b0),
    .clr        (1'b0),
    .wr_en      (wr_cs),
    .wr_val     (req.wdata[PPSC_POS_WAKE_ENABLE]),
    .q          (wake_enable)
  );

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic [1:0] next_pstate;
  logic [3:0] next_data_select;

  // next state and select; reserved bits are not stored
  always_comb begin
    next_pstate      = pstate;
    next_data_select = data_select;
    if (state_accept) begin
      next_pstate = wr_state;
    end
    if (wr_cs && DATA_IMPL) begin
      next_data_select = req.wdata[PPSC_POS_SELECT_LO +: 4];
    end
    if (!func_rst_n) begin
      next_pstate      = PPSC_RST_STATE;
      next_data_select = PPSC_RST_SELECT;
    end
  end

  // register only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pstate      <= PPSC_RST_STATE;
      data_select <= PPSC_RST_SELECT;
    end else begin
      pstate      <= next_pstate;
      data_select <= next_data_select;
    end
  end

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  // scale is fixed zero without the data register; select forced zero too
  always_comb begin
    ctrl_img = 16'h0000;
    ctrl_img[PPSC_POS_WAKE_STATUS]     = wake_status;
    ctrl_img[PPSC_POS_SCALE_LO +: 2]   = PPSC_RST_SCALE;
    ctrl_img[PPSC_POS_SELECT_LO +: 4]  = DATA_IMPL ? data_select : 4'h0;
    ctrl_img[PPSC_POS_WAKE_ENABLE]     = wake_enable;
    ctrl_img[PPSC_POS_STATE_LO +: 2]   = pstate;
  end

  assign bridge_img = BRIDGE_VALUE;

  ppsc_read_mux u_read_mux (
    .addr       (req.addr),
    .ctrl_stat  (ctrl_img),
    .bridge     (bridge_img),
    .irq_status (irq_status),
    .irq_mask   (irq_mask),
    .rdata      (rdata_c)
  );

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  logic [IRQ_W_T-1:0] evt;
  logic [IRQ_W_T-1:0] next_irq_status;
  logic [IRQ_W_T-1:0] next_irq_mask;

  // events: wake seen, state changed, state write refused
  always_comb begin
    evt = '0;
    evt[PPSC_IRQ_WAKE]   = wake_event;
    evt[PPSC_IRQ_STATE]  = state_accept && (wr_state != pstate);
    evt[PPSC_IRQ_REJECT] = wr_cs && !state_ok(wr_state);
  end

  // read clears, a new event in the same cycle survives
  always_comb begin
    next_irq_status = (rd_irq ? '0 : irq_status) | evt;
    next_irq_mask   = irq_mask;
    if (req.wr && hit(req.addr, PPSC_OFF_IRQ_MASK)) begin
      next_irq_mask = req.wdata[IRQ_W_T-1:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic       next_wake_out_n;
  ppsc_bus_s  next_sec_bus;

  // wake pin low only while status and enable; bus control gated by enable bit
  always_comb begin
    next_wake_out_n = !(wake_status && wake_enable);
    next_sec_bus    = '0;
    if (bridge_img[PPSC_POS_BUS_POWER_CLOCK_CTRL_ENABLE]) begin
      case (next_pstate)
        PPSC_D2:    next_sec_bus.clk_stop = 1'b1;
        PPSC_D3HOT: begin
          next_sec_bus.clk_stop = 1'b1;
          next_sec_bus.pwr_off  = !bridge_img[PPSC_POS_D3_BUS_SEL];
        end
        default:    next_sec_bus = '0;
      endcase
    end
  end

  // register outputs and interrupt state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata       <= 32'h00000000;
      power_state <= PPSC_RST_STATE;
      sec_bus     <= '0;
      wake_out_n  <= 1'b1;
      irq         <= 1'b0;
      irq_status  <= PPSC_RST_IRQ;
      irq_mask    <= PPSC_RST_IRQ;
    end else begin
      rdata       <= req.rd ? rdata_c : 32'h00000000;
      power_state <= next_pstate;
      sec_bus     <= next_sec_bus;
      wake_out_n  <= next_wake_out_n;
      irq         <= |(next_irq_status & next_irq_mask);
      irq_status  <= next_irq_status;
      irq_mask    <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wake_set;
    @(posedge core_clk) disable iff (!arst_n)
      (wake_event && (func_rst_n || WAKE_FROM_D3COLD)) |=> wake_status;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake status not set");

  property p_wake_clr;
    @(posedge core_clk) disable iff (!arst_n)
      (wr_cs && req.wdata[PPSC_POS_WAKE_STATUS] && !wake_event) |=> !wake_status;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake status not cleared");

  property p_wake_keep;
    @(posedge core_clk) disable iff (!arst_n)
      (wake_status && !(wr_cs && req.wdata[PPSC_POS_WAKE_STATUS]) && (func_rst_n || WAKE_FROM_D3COLD))
      |=> wake_status;
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake status lost");

  property p_pin_gate;
    @(posedge core_clk) disable iff (!arst_n) !wake_enable |=> wake_out_n;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("wake pin without enable");

  property p_pin_drive;
    @(posedge core_clk) disable iff (!arst_n)
      (wake_status && wake_enable) |=> !wake_out_n;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("wake pin not driven");

  property p_scale_zero;
    @(posedge core_clk) disable iff (!arst_n)
      (req.rd && hit(req.addr, PPSC_OFF_PWR_CTRL_STAT)) |=> (rdata[14:13] == 2'h0);
  endproperty
  a_scale_zero: assert property (p_scale_zero) else $error("data scale nonzero");

  property p_select_zero;
    @(posedge core_clk) disable iff (!arst_n)
      (req.rd && hit(req.addr, PPSC_OFF_PWR_CTRL_STAT) && !DATA_IMPL) |=> (rdata[12:9] == 4'h0);
  endproperty
  a_select_zero: assert property (p_select_zero) else $error("data select nonzero");

  property p_state_take;
    @(posedge core_clk) disable iff (!arst_n)
      (state_accept && func_rst_n) |=> (pstate == $past(wr_state)) && (power_state == pstate);
  endproperty
  a_state_take: assert property (p_state_take) else $error("power state not taken");

  property p_state_reject;
    @(posedge core_clk) disable iff (!arst_n)
      (wr_cs && !state_ok(wr_state) && func_rst_n) |=> $stable(pstate);
  endproperty
  a_state_reject: assert property (p_state_reject) else $error("bad state accepted");

  property p_bridge_ro;
    @(posedge core_clk) disable iff (!arst_n)
      (req.rd && hit(req.addr, PPSC_OFF_BRIDGE_SUPPORT)) |=> (rdata == {24'h000000, BRIDGE_VALUE});
  endproperty
  a_bridge_ro: assert property (p_bridge_ro) else $error("bridge byte changed");

  property p_bus_off;
    @(posedge core_clk) disable iff (!arst_n)
      !bridge_img[PPSC_POS_BUS_POWER_CLOCK_CTRL_ENABLE] |=> (sec_bus == '0);
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus control while disabled");

  // ----------------------------------------------------------------
  // interrupt and function reset checks
  // ----------------------------------------------------------------
  property p_irq_wake;
    @(posedge core_clk) disable iff (!arst_n) wake_event |=> irq_status[PPSC_IRQ_WAKE];
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("wake event not recorded");

  property p_irq_reject;
    @(posedge core_clk) disable iff (!arst_n)
      (wr_cs && !state_ok(wr_state)) |=> irq_status[PPSC_IRQ_REJECT];
  endproperty
  a_irq_reject: assert property (p_irq_reject) else $error("refused state write not recorded");

  property p_irq_clear;
    @(posedge core_clk) disable iff (!arst_n)
      (rd_irq && (evt == '0)) |=> (irq_status == '0);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read did not clear");

  property p_irq_level;
    @(posedge core_clk) disable iff (!arst_n) irq == |(irq_status & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_func_reset;
    @(posedge core_clk) disable iff (!arst_n)
      !func_rst_n |=> (pstate == PPSC_RST_STATE) && (power_state == PPSC_RST_STATE);
  endproperty
  a_func_reset: assert property (p_func_reset) else $error("function reset left power state");

  c_wake_pin:  cover property (@(posedge core_clk) disable iff (!arst_n) !wake_out_n ##1 wake_out_n);
  c_to_d3:     cover property (@(posedge core_clk) disable iff (!arst_n) power_state == PPSC_D3HOT);
  c_reject:    cover property (@(posedge core_clk) disable iff (!arst_n) evt[PPSC_IRQ_REJECT]);
  c_irq:       cover property (@(posedge core_clk) disable iff (!arst_n) irq);
  c_func_rst:  cover property (@(posedge core_clk) disable iff (!arst_n) !func_rst_n ##1 func_rst_n);

endmodule : ppsc_top

// >>> rtl/ppsc_pkg.sv
/*
  package for the power-state control block: register offsets, field
  positions, reset values, power state and event encodings.
  assumes a plain strobe register port and one clock domain.
*/
package ppsc_pkg;

  // register offsets, low address bits are significant
  localparam logic [3:0] PPSC_OFF_PWR_CTRL_STAT  = 4'h4;  // control/status, two bytes
  localparam logic [3:0] PPSC_OFF_BRIDGE_SUPPORT = 4'h6;  // bridge extension byte
  localparam logic [3:0] PPSC_OFF_IRQ_STATUS     = 4'h8;  // sticky event bits
  localparam logic [3:0] PPSC_OFF_IRQ_MASK       = 4'hc;  // event enables

  // control/status field positions
  localparam int PPSC_POS_WAKE_STATUS = 15;
  localparam int PPSC_POS_SCALE_LO    = 13;
  localparam int PPSC_POS_SELECT_LO   = 9;
  localparam int PPSC_POS_WAKE_ENABLE = 8;
  localparam int PPSC_POS_STATE_LO    = 0;

  // bridge extension field positions
  localparam int PPSC_POS_BUS_POWER_CLOCK_CTRL_ENABLE     = 7;
  localparam int PPSC_POS_D3_BUS_SEL  = 6;

  // reset values
  localparam logic [1:0] PPSC_RST_STATE    = 2'h0;
  localparam logic [3:0] PPSC_RST_SELECT   = 4'h0;
  localparam logic [1:0] PPSC_RST_SCALE    = 2'h0;
  localparam logic [7:0] PPSC_RST_BRIDGE   = 8'h00;
  localparam logic [2:0] PPSC_RST_IRQ      = 3'h0;

  // interrupt status bit positions
  localparam int PPSC_IRQ_WAKE    = 0;  // wake event seen
  localparam int PPSC_IRQ_STATE   = 1;  // power state changed
  localparam int PPSC_IRQ_REJECT  = 2;  // unsupported state write refused
  localparam int PPSC_IRQ_W       = 3;

  // power state encoding
  typedef enum logic [1:0] {
    PPSC_D0     = 2'h0,
    PPSC_D1     = 2'h1,
    PPSC_D2     = 2'h2,
    PPSC_D3HOT  = 2'h3
  } ppsc_pstate_e;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } ppsc_req_s;

  // secondary bus control derived from state
  typedef struct packed {
    logic clk_stop;
    logic pwr_off;
  } ppsc_bus_s;

endpackage : ppsc_pkg

// >>> rtl/ppsc_sticky_bit.sv
/*
  one wake-path flag that can be sticky across function resets.
  assumes the set input is a one-cycle or level event and the clear is a
  one-cycle software write; set wins over clear.
*/
`timescale 1ns/100ps
module ppsc_sticky_bit #(
  parameter bit STICKY = 1'b0
) (
  // clock and resets
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic func_rst_n,
  // control
  input  wire logic set,
  input  wire logic clr,
  input  wire logic wr_en,
  input  wire logic wr_val,
  // state
  output logic      q
);

  logic next_q;  // next flag value

  // next value: set beats clear, write loads
  always_comb begin
    next_q = q;
    if (wr_en) begin
      next_q = wr_val;
    end
    if (clr) begin
      next_q = 1'b0;
    end
    if (set) begin
      next_q = 1'b1;
    end
    if (!STICKY && !func_rst_n) begin
      next_q = 1'b0;  // non-sticky bits follow the function reset
    end
  end

  // register only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

endmodule : ppsc_sticky_bit

// >>> rtl/ppsc_read_mux.sv
/*
  read data selection for the power-state control registers.
  assumes all inputs are registered state; output is combinational.
*/
`timescale 1ns/100ps
module ppsc_read_mux (
  // address
  input  wire logic [3:0]  addr,
  // register images
  input  wire logic [15:0] ctrl_stat,
  input  wire logic [7:0]  bridge,
  input  wire logic [2:0]  irq_status,
  input  wire logic [2:0]  irq_mask,
  // result
  output logic      [31:0] rdata
);
  import ppsc_pkg::*;

  // pick the word, unmapped reads zero
  always_comb begin
    case (addr)
      PPSC_OFF_PWR_CTRL_STAT:  rdata = {16'h0000, ctrl_stat};
      PPSC_OFF_BRIDGE_SUPPORT: rdata = {24'h000000, bridge};
      PPSC_OFF_IRQ_STATUS:     rdata = {29'h0, irq_status};
      PPSC_OFF_IRQ_MASK:       rdata = {29'h0, irq_mask};
      default:                 rdata = 32'h00000000;
    endcase
  end

endmodule : ppsc_read_mux

// >>> tb/ppsc_host_model.sv
/*
  host software model: drives the register strobe port of the power-state
  control block, one access per task call.
  assumes one clock, tasks are entered right after a rising edge.
*/
`timescale 1ns/100ps
module ppsc_host_model (
  // clock
  input  wire logic                core_clk,
  // register port
  output ppsc_pkg::ppsc_req_s      req,
  input  wire logic         [31:0] rdata
);
  import ppsc_pkg::*;

  // -------------------------------------------------------------
  // idle bus
  // -------------------------------------------------------------
  initial begin
    req = '0;
  end

  // -------------------------------------------------------------
  // single write, strobe dropped and one edge left before return
  // -------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] addr, input logic [15:0] data);
    logic [15:0] val;
    val = data;
    // reserved control bits always go out as zero
    if (addr == PPSC_OFF_PWR_CTRL_STAT) begin
      val = data & 16'hff03;
    end
    req.addr  <= addr;
    req.wdata <= val;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr    <= 1'b0;
    @(posedge core_clk);
  endtask : wr_reg

  // -------------------------------------------------------------
  // single read, data taken in the cycle after the strobe
  // -------------------------------------------------------------
  task automatic rd_reg(input logic [3:0] addr, output logic [31:0] data);
    req.addr <= addr;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd   <= 1'b0;
    #1;
    data = rdata;
    @(posedge core_clk);
  endtask : rd_reg

  // -------------------------------------------------------------
  // boot: sticky wake status and enable cleared explicitly
  // -------------------------------------------------------------
  task automatic boot_clear();
    wr_reg(PPSC_OFF_PWR_CTRL_STAT, 16'h8000);
  endtask : boot_clear

endmodule : ppsc_host_model

// >>> tb/tb_top.sv
/*
  self-checking bench for the power-state control block: a table of
  register accesses, then interrupt, wake and function reset cases.
  assumes the package defaults; a second instance lacks d1, d2 and sticky bits.
*/
`timescale 1ns/100ps
module tb_top;
  import ppsc_pkg::*;

  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic        core_clk;     // 250 mhz
  logic        arst_n;       // async reset
  logic        func_rst_n;   // function reset
  logic        wake_event;   // function wake source
  ppsc_req_s   req;          // shared register port
  logic [31:0] rdata;        // main instance read data
  logic [1:0]  power_state;  // main instance state
  ppsc_bus_s   sec_bus;      // main instance bus control
  logic        wake_out_n;   // main wake output
  logic        irq;          // main interrupt
  logic [1:0]  power_state2; // reduced instance state
  logic        wake_out2_n;  // reduced wake output
  logic        irq2;         // reduced interrupt
  logic [31:0] rd_val;       // last read value
  int          n_fail;       // mismatches
  int          check_count;  // comparisons

  // table row: access, expected read back and states
  typedef struct {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [31:0] exp_rd;
    logic [1:0]  exp_ps;
    logic [1:0]  exp_ps2;
  } ppsc_row_s;

  ppsc_row_s rows [6] = '{
    '{4'h4, 16'h7e01, 32'h0000_0001, 2'h1, 2'h0},
    '{4'h4, 16'h0002, 32'h0000_0002, 2'h2, 2'h0},
    '{4'h4, 16'h0103, 32'h0000_0103, 2'h3, 2'h3},
    '{4'h6, 16'h00ff, 32'h0000_0000, 2'h3, 2'h3},
    '{4'h2, 16'hffff, 32'h0000_0000, 2'h3, 2'h3},
    '{4'h4, 16'h0000, 32'h0000_0000, 2'h0, 2'h0}
  };

  // -------------------------------------------------------------
  // clock and instances
  // -------------------------------------------------------------
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  ppsc_host_model host (.core_clk(core_clk), .req(req), .rdata(rdata));

  ppsc_top DUT (
    .core_clk(core_clk), .arst_n(arst_n), .func_rst_n(func_rst_n), .req(req), .rdata(rdata),
    .wake_event(wake_event), .power_state(power_state), .sec_bus(sec_bus),
    .wake_out_n(wake_out_n), .irq(irq));

  // reduced function: no d1, d2, wake bits not sticky
  ppsc_top #(.WAKE_FROM_D3COLD(1'b0), .D1_SUPPORTED(1'b0), .D2_SUPPORTED(1'b0)) DUT2 (
    .core_clk(core_clk), .arst_n(arst_n), .func_rst_n(func_rst_n), .req(req), .rdata(),
    .wake_event(wake_event), .power_state(power_state2), .sec_bus(),
    .wake_out_n(wake_out2_n), .irq(irq2));

  // -------------------------------------------------------------
  // compare and closing
  // -------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // one-cycle pulse on a bench input, edge aligned
  task automatic pulse_wake();
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : pulse_wake

  // -------------------------------------------------------------
  // watchdog
  // -------------------------------------------------------------
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    arst_n = 1'b0;
    func_rst_n = 1'b1;
    wake_event = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    // reset values
    check("reset state", {30'h0, power_state}, 32'h0);
    check("reset wake out", {31'h0, wake_out_n}, 32'h1);
    check("reset irq", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    host.rd_reg(PPSC_OFF_PWR_CTRL_STAT, rd_val);
    check("reset ctrl", rd_val, 32'h0);
    host.rd_reg(PPSC_OFF_BRIDGE_SUPPORT, rd_val);
    check("reset bridge", rd_val, 32'h0);

    // table of accesses
    foreach (rows[i]) begin
      host.wr_reg(rows[i].addr, rows[i].wdata);
      host.rd_reg(rows[i].addr, rd_val);
      check("table read", rd_val, rows[i].exp_rd);
      check("table state", {30'h0, power_state}, {30'h0, rows[i].exp_ps});
      check("reduced state", {30'h0, power_state2}, {30'h0, rows[i].exp_ps2});
      check("bus ctrl", {30'h0, sec_bus}, 32'h0);
    end

    // interrupt: unmask, read clears, unmasked state-change bit seen
    host.wr_reg(PPSC_OFF_IRQ_MASK, 16'h0007);
    #1;
    check("irq on", {31'h0, irq}, 32'h1);
    check("reduced irq", {31'h0, irq2}, 32'h1);
    @(posedge core_clk);
    host.rd_reg(PPSC_OFF_IRQ_STATUS, rd_val);
    check("irq status", rd_val, 32'h2);
    #1;
    check("irq cleared", {31'h0, irq}, 32'h0);
    check("reduced irq clr", {31'h0, irq2}, 32'h0);
    @(posedge core_clk);

    // wake with enable clear: status sets, output stays high
    pulse_wake();
    check("wake out off", {31'h0, wake_out_n}, 32'h1);
    check("wake irq", {31'h0, irq}, 32'h1);
    @(posedge core_clk);
    host.rd_reg(PPSC_OFF_PWR_CTRL_STAT, rd_val);
    check("wake status", rd_val, 32'h0000_8000);
    host.wr_reg(PPSC_OFF_PWR_CTRL_STAT, 16'h0100);
    #1;
    check("wake out on", {31'h0, wake_out_n}, 32'h0);
    @(posedge core_clk);
    host.rd_reg(PPSC_OFF_PWR_CTRL_STAT, rd_val);
    check("zero write", rd_val, 32'h0000_8100);
    host.wr_reg(PPSC_OFF_PWR_CTRL_STAT, 16'h8100);
    #1;
    check("wake out clr", {31'h0, wake_out_n}, 32'h1);
    @(posedge core_clk);
    host.rd_reg(PPSC_OFF_PWR_CTRL_STAT, rd_val);
    check("one write", rd_val, 32'h0000_0100);

    // function reset: sticky bits survive only on the main instance
    host.wr_reg(PPSC_OFF_PWR_CTRL_STAT, 16'h0103);
    pulse_wake();
    @(posedge core_clk);
    check("pre reset out", {31'h0, wake_out2_n}, 32'h0);
    func_rst_n <= 1'b0;
    @(posedge core_clk);
    func_rst_n <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    #1;
    check("sticky out", {31'h0, wake_out_n}, 32'h0);
    check("plain out", {31'h0, wake_out2_n}, 32'h1);
    check("func state", {30'h0, power_state}, 32'h0);
    check("func state2", {30'h0, power_state2}, 32'h0);
    @(posedge core_clk);
    host.boot_clear();
    host.rd_reg(PPSC_OFF_PWR_CTRL_STAT, rd_val);
    check("boot clear", rd_val, 32'h0);
    check("boot out", {31'h0, wake_out_n}, 32'h1);
    report_and_stop();
  end

endmodule : tb_top
